// file: inc/adc_ctrl_cfg.svh
// Register map, field positions, reset values and fixed factors of the converter control block.
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH

// ==========================================================================
// Register byte addresses
// ==========================================================================
`define OFS_CTL_ZERO 8'h00
`define OFS_CTL_ONE 8'h04
`define OFS_CLK_SETUP 8'h08
`define OFS_REF_CTL 8'h0C
`define OFS_INT_CTL 8'h10
`define OFS_RES_LOW 8'h14
`define OFS_RES_MID 8'h18
`define OFS_RES_HIGH 8'h1C

// ==========================================================================
// Field positions
// ==========================================================================
`define F_OSR 3:0
`define F_RATE 6:4
`define F_FILT 7
`define F_FRST 0
`define F_SLEEP 1
`define F_POFF 2
`define F_PREF 3
`define F_DONE 4
`define F_LATCH 5
`define F_CKDIV 4:0
`define F_IREF 0
`define F_GIE 0
`define F_CIE 1
`define F_IFLAG 2
`define F_RATE_CHOP1 0
`define F_RATE_N12 2

// ==========================================================================
// Reset values
// ==========================================================================
`define RST_OSR 4'h1
`define RST_RATE 3'h0
`define RST_FILT 1'h1
`define RST_POFF 1'h1
`define RST_CKDIV 5'h00

// ==========================================================================
// Fixed factors
// ==========================================================================
`define CKDIV_BYPASS 5'h1F
`define N_LONG_LIM 5'h1D
`define N_SHORT_LIM 5'h0B
`define OSR_BASE 17'h08000
`define LAT_SINC2 3'h3
`define LAT_SINC3 3'h4
`define RES_MAX 24'h7FFFFF
`define RES_MIN 24'h800000

`endif

// file: inc/adc_ctrl_pkg.sv
// Types shared by the converter control block.
package adc_ctrl_pkg;

   typedef enum logic [1:0] {
      MODE_POWER_DOWN,
      MODE_SLEEP,
      MODE_NORMAL,
      MODE_RESET
   } conv_mode_e;

   typedef struct packed {
      logic iref_on;
      logic pga_on;
      logic mod_on;
      logic filter_on;
      logic filter_rst;
      logic pos_ref_sel;
   } analog_ctl_s;

endpackage : adc_ctrl_pkg

// file: verilog/adc_rate_div.sv
// Converter source clock enable derived from the system clock.
`timescale 1ns/1ps
`include "adc_ctrl_cfg.svh"

module adc_rate_div
   import adc_ctrl_pkg::*;
(
   input wire logic i_clk, // System clock.
   input wire logic i_rst_n, // Synchronous reset, active low.
   input wire logic i_run, // Counting allowed.
   input wire logic [4:0] i_div_sel, // Clock divider select.
   output logic o_tick // One-cycle source clock enable.
);

   logic [5:0] cnt_r;
   logic [5:0] cnt_nxt;
   logic [5:0] cnt_lim;
   logic bypass;
   logic wrap;

   // Divide by two, then by select plus one: wrap after 2*(sel+1) cycles.
   assign bypass = (i_div_sel == `CKDIV_BYPASS);
   assign cnt_lim = {i_div_sel, 1'b1};
   assign wrap = (cnt_r >= cnt_lim);
   assign cnt_nxt = (!i_run || wrap) ? 6'h00 : 6'(cnt_r + 6'h01);
   assign o_tick = i_run && (bypass || wrap);

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cnt_r <= 6'h00;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // ==========================================================================
   // Checks
   // ==========================================================================
   a_bypass_every_cycle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_run && bypass) |-> o_tick) else $error("bypass code did not pass the system clock");
   a_divided_spacing: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (o_tick && !bypass && $stable(i_div_sel) && i_run) ##1 $stable(i_div_sel) |-> !o_tick)
      else $error("divided tick too close");

endmodule : adc_rate_div

// file: verilog/delta_sigma_adc_control.sv
// Control logic for a 24-bit delta-sigma converter: rate timing, modes, start, results.
//
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`include "adc_ctrl_cfg.svh"

// Contract
// - Word rate is source over N, chop, OSR.
// - Modulator clock is source divided 12 or 30.
// - Chop factor 1 or 2 from rate mode; the code takes 2 only with SINC2.
// - Rate mode 000 gives N 30, chop 2; with SINC3 the code uses chop 1.
// - Oversampling code 0010 8192, 0001 16384.
// - Source is system clock halved, over select+1.
// - Divider code 11111 passes the system clock.
// - Power off shuts PGA, modulator and filter.
// - Sleep keeps PGA, filter on, modulator off.
// - All bits clear runs everything normally.
// - Reset bit holds filter in reset only.
// - Internal reference follows its own enable bit.
// - Filter reset high then low starts conversion.
// - Done flag sets at each conversion end.
// - Interrupt flag sets; output needs both enables.
// - Latching holds result, discards newer conversions.
// - Positive reference follows its select bit.
// - Result is 24-bit two's complement.
// - Result readable as low, middle, high bytes.
// - Out-of-range results clamp, never wrap.
// - Latency is 3 words SINC2, 4 SINC3.
module delta_sigma_adc_control
   import adc_ctrl_pkg::*;
(
   input wire logic i_clk, // System clock, 50 MHz.
   input wire logic i_rst_n, // Synchronous reset, active low.
   input wire logic [7:0] i_address, // Avalon byte address.
   input wire logic i_read, // Avalon read request.
   input wire logic i_write, // Avalon write request.
   input wire logic [31:0] i_writedata, // Avalon write data.
   input wire logic [3:0] i_byteenable, // Avalon byte enables.
   input wire logic [25:0] i_raw_data, // Signed filter output before clamping.
   output logic [31:0] o_readdata, // Avalon read data.
   output logic o_waitrequest, // Avalon wait request.
   output analog_ctl_s o_analog, // Analog power and reference controls.
   output logic o_irq, // Converter interrupt, active high.
   output logic o_word_pulse // One-cycle pulse when a result is stored.
);

   // ==========================================================================
   // Register state
   // ==========================================================================
   logic [3:0] osr_sel_r;
   logic [2:0] rate_sel_r;
   logic filt_sel_r;
   logic frst_r;
   logic sleep_r;
   logic poff_r;
   logic pref_r;
   logic done_r;
   logic latch_r;
   logic [4:0] ckdiv_r;
   logic iref_r;
   logic gie_r;
   logic cie_r;
   logic iflag_r;
   logic [23:0] result_r;
   logic wait_r;
   logic [31:0] rdata_r;
   logic started_r;
   logic [4:0] mod_cnt_r;
   logic [16:0] smp_cnt_r;
   logic [2:0] lat_cnt_r;
   analog_ctl_s analog_r;
   logic irq_r;
   logic word_r;

   // ==========================================================================
   // Bus decode
   // ==========================================================================
   logic bus_req;
   logic wr_hit;
   logic rd_cap;
   logic wr_ctl0;
   logic wr_ctl1;
   logic wr_clk;
   logic wr_ref;
   logic wr_int;
   logic [7:0] wd;
   logic [31:0] rd_mux;

   assign bus_req = i_read || i_write;
   // The access completes in the cycle in which waitrequest is low.
   assign wr_hit = i_write && !wait_r && i_byteenable[0];
   assign rd_cap = i_read && wait_r;
   assign wd = i_writedata[7:0];
   assign wr_ctl0 = wr_hit && (i_address == `OFS_CTL_ZERO);
   assign wr_ctl1 = wr_hit && (i_address == `OFS_CTL_ONE);
   assign wr_clk = wr_hit && (i_address == `OFS_CLK_SETUP);
   assign wr_ref = wr_hit && (i_address == `OFS_REF_CTL);
   assign wr_int = wr_hit && (i_address == `OFS_INT_CTL);

   always_comb begin
      rd_mux = 32'h00000000;
      unique case (i_address)
         `OFS_CTL_ZERO: rd_mux[7:0] = {filt_sel_r, rate_sel_r, osr_sel_r};
         `OFS_CTL_ONE: rd_mux[5:0] = {latch_r, done_r, pref_r, poff_r, sleep_r, frst_r};
         `OFS_CLK_SETUP: rd_mux[4:0] = ckdiv_r;
         `OFS_REF_CTL: rd_mux[0] = iref_r;
         `OFS_INT_CTL: rd_mux[2:0] = {iflag_r, cie_r, gie_r};
         `OFS_RES_LOW: rd_mux[7:0] = result_r[7:0];
         `OFS_RES_MID: rd_mux[7:0] = result_r[15:8];
         `OFS_RES_HIGH: rd_mux[7:0] = result_r[23:16];
         default: rd_mux = 32'h00000000;
      endcase
   end

   // ==========================================================================
   // Operating mode
   // ==========================================================================
   conv_mode_e mode;
   analog_ctl_s analog_nxt;

   assign mode = poff_r ? MODE_POWER_DOWN :
                 sleep_r ? MODE_SLEEP :
                 frst_r ? MODE_RESET : MODE_NORMAL;

   always_comb begin
      analog_nxt = '0;
      analog_nxt.iref_on = iref_r;
      analog_nxt.pos_ref_sel = pref_r;
      unique case (mode)
         MODE_POWER_DOWN: begin
            analog_nxt.pga_on = 1'b0;
         end
         MODE_SLEEP: begin
            analog_nxt.pga_on = 1'b1;
            analog_nxt.filter_on = 1'b1;
         end
         MODE_NORMAL: begin
            analog_nxt.pga_on = 1'b1;
            analog_nxt.mod_on = 1'b1;
            analog_nxt.filter_on = 1'b1;
         end
         MODE_RESET: begin
            analog_nxt.pga_on = 1'b1;
            analog_nxt.mod_on = 1'b1;
            analog_nxt.filter_on = 1'b1;
            analog_nxt.filter_rst = 1'b1;
         end
      endcase
   end

   // ==========================================================================
   // Rate timing
   // ==========================================================================
   logic run;
   logic mclk_tick;
   logic [4:0] n_lim;
   logic chop_two;
   logic [16:0] osr_val;
   logic [16:0] smp_lim;
   logic mod_wrap;
   logic smp_wrap;
   logic odr_tick;
   logic [2:0] lat_need;
   logic lat_ok;
   logic done_set;
   logic start_pulse;
   logic cnt_clear;

   // A high-to-low write of the filter reset bit starts a fresh sequence.
   assign start_pulse = wr_ctl1 && frst_r && !wd[`F_FRST];
   assign run = started_r && (mode == MODE_NORMAL);
   assign cnt_clear = start_pulse || (mode == MODE_RESET) || (mode == MODE_POWER_DOWN);

   adc_rate_div u_rate_div (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_run(run),
      .i_div_sel(ckdiv_r),
      .o_tick(mclk_tick)
   );

   assign n_lim = rate_sel_r[`F_RATE_N12] ? `N_SHORT_LIM : `N_LONG_LIM;
   // Chop only doubles the word for SINC2; SINC3 ignores it.
   assign chop_two = !rate_sel_r[`F_RATE_CHOP1] && !filt_sel_r;
   assign osr_val = `OSR_BASE >> osr_sel_r;
   assign smp_lim = chop_two ? 17'({osr_val[15:0], 1'b0} - 17'h00001) : 17'(osr_val - 17'h00001);
   // A rate change can leave a counter above its new limit; wrap there instead of running round.
   assign mod_wrap = (mod_cnt_r >= n_lim);
   assign smp_wrap = (smp_cnt_r >= smp_lim);
   assign odr_tick = run && mclk_tick && mod_wrap && smp_wrap;
   assign lat_need = filt_sel_r ? `LAT_SINC3 : `LAT_SINC2;
   assign lat_ok = (lat_cnt_r >= 3'(lat_need - 3'h1));
   assign done_set = odr_tick && lat_ok;

   // ==========================================================================
   // Result clamp
   // ==========================================================================
   logic [23:0] clamped;
   logic raw_over;
   logic raw_under;

   assign raw_over = !i_raw_data[25] && (i_raw_data[24:23] != 2'h0);
   assign raw_under = i_raw_data[25] && (i_raw_data[24:23] != 2'h3);
   assign clamped = raw_over ? `RES_MAX : raw_under ? `RES_MIN : i_raw_data[23:0];

   // ==========================================================================
   // Flag next values: a hardware set wins over a software clear.
   // ==========================================================================
   logic done_nxt;
   logic iflag_nxt;

   assign done_nxt = done_set ? 1'b1 :
                     (start_pulse || (wr_ctl1 && !wd[`F_DONE])) ? 1'b0 : done_r;
   assign iflag_nxt = done_set ? 1'b1 : (wr_int && !wd[`F_IFLAG]) ? 1'b0 : iflag_r;

   // ==========================================================================
   // Registers
   // ==========================================================================
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         osr_sel_r <= `RST_OSR;
         rate_sel_r <= `RST_RATE;
         filt_sel_r <= `RST_FILT;
         ckdiv_r <= `RST_CKDIV;
         iref_r <= 1'b0;
         gie_r <= 1'b0;
         cie_r <= 1'b0;
      end else begin
         if (wr_ctl0) begin
            osr_sel_r <= wd[`F_OSR];
            rate_sel_r <= wd[`F_RATE];
            filt_sel_r <= wd[`F_FILT];
         end
         if (wr_clk) begin
            ckdiv_r <= wd[`F_CKDIV];
         end
         if (wr_ref) begin
            iref_r <= wd[`F_IREF];
         end
         if (wr_int) begin
            gie_r <= wd[`F_GIE];
            cie_r <= wd[`F_CIE];
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         frst_r <= 1'b0;
         sleep_r <= 1'b0;
         poff_r <= `RST_POFF;
         pref_r <= 1'b0;
         latch_r <= 1'b0;
      end else if (wr_ctl1) begin
         frst_r <= wd[`F_FRST];
         sleep_r <= wd[`F_SLEEP];
         poff_r <= wd[`F_POFF];
         pref_r <= wd[`F_PREF];
         latch_r <= wd[`F_LATCH];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         wait_r <= 1'b1;
         rdata_r <= 32'h00000000;
      end else begin
         wait_r <= !(bus_req && wait_r);
         if (rd_cap) begin
            rdata_r <= rd_mux;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         started_r <= 1'b0;
         mod_cnt_r <= 5'h00;
         smp_cnt_r <= 17'h00000;
         lat_cnt_r <= 3'h0;
      end else begin
         if (start_pulse) begin
            started_r <= 1'b1;
         end else if (mode == MODE_POWER_DOWN) begin
            started_r <= 1'b0;
         end
         if (cnt_clear) begin
            mod_cnt_r <= 5'h00;
            smp_cnt_r <= 17'h00000;
            lat_cnt_r <= 3'h0;
         end else if (run && mclk_tick) begin
            mod_cnt_r <= mod_wrap ? 5'h00 : 5'(mod_cnt_r + 5'h01);
            if (mod_wrap) begin
               smp_cnt_r <= smp_wrap ? 17'h00000 : 17'(smp_cnt_r + 17'h00001);
            end
            if (odr_tick && !lat_ok) begin
               lat_cnt_r <= 3'(lat_cnt_r + 3'h1);
            end
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         done_r <= 1'b0;
         iflag_r <= 1'b0;
         result_r <= 24'h000000;
         word_r <= 1'b0;
         irq_r <= 1'b0;
         analog_r <= '0;
      end else begin
         done_r <= done_nxt;
         iflag_r <= iflag_nxt;
         if (done_set && !latch_r) begin
            result_r <= clamped;
         end
         word_r <= done_set && !latch_r;
         irq_r <= iflag_r && gie_r && cie_r;
         analog_r <= analog_nxt;
      end
   end

   assign o_readdata = rdata_r;
   assign o_waitrequest = wait_r;
   assign o_analog = analog_r;
   assign o_irq = irq_r;
   assign o_word_pulse = word_r;

   // ==========================================================================
   // Checks
   // ==========================================================================
   a_power_off_all: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      poff_r |=> (!o_analog.pga_on && !o_analog.mod_on && !o_analog.filter_on))
      else $error("power off left analog parts on");
   a_sleep_mod_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (!poff_r && sleep_r) |=> (o_analog.pga_on && !o_analog.mod_on && o_analog.filter_on))
      else $error("sleep mode controls wrong");
   a_normal_all_on: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (!poff_r && !sleep_r && !frst_r) |=> (o_analog.mod_on && o_analog.filter_on && !o_analog.filter_rst))
      else $error("normal mode controls wrong");
   a_reset_filter_held: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (!poff_r && !sleep_r && frst_r) |=> (o_analog.mod_on && o_analog.filter_rst))
      else $error("reset mode did not hold the filter");
   a_iref_follows: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      ##1 (o_analog.iref_on == $past(iref_r))) else $error("reference enable not followed");
   a_done_on_word: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      done_set |=> (done_r && iflag_r)) else $error("conversion end did not set flags");
   a_irq_needs_enables: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_irq |-> ($past(gie_r) && $past(cie_r) && $past(iflag_r))) else $error("interrupt without enables");
   a_latch_holds: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      latch_r |=> $stable(result_r)) else $error("latched result changed");
   a_clamp_high: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (done_set && !latch_r && raw_over) |=> (result_r == `RES_MAX)) else $error("high result wrapped");
   a_start_clears_done: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (start_pulse && !done_set) |=> (!done_r && started_r)) else $error("start did not clear done");
   a_first_word_late: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (odr_tick && (lat_cnt_r == 3'h0)) |-> !done_set) else $error("first word not held back");
   c_word_done: cover property (@(posedge i_clk) disable iff (!i_rst_n) done_set ##1 done_r);
   c_irq_raise: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(o_irq));
   c_latched_discard: cover property (@(posedge i_clk) disable iff (!i_rst_n) done_set && latch_r);

endmodule : delta_sigma_adc_control

// file: tb/test_delta_sigma_adc_control.sv
// Self-checking bench for the delta-sigma converter control block.
`timescale 1ns/1ps
`include "adc_ctrl_cfg.svh"

module test_delta_sigma_adc_control
   import adc_ctrl_pkg::*;
();
   // ==========================================================================
   // Stimulus signals and tables
   // ==========================================================================
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [7:0] i_address = 8'h00;
   logic i_read = 1'b0;
   logic i_write = 1'b0;
   logic [31:0] i_writedata = 32'h0;
   logic [3:0] i_byteenable = 4'hF;
   logic [25:0] i_raw_data = 26'h0;
   logic [31:0] o_readdata;
   logic o_waitrequest;
   analog_ctl_s o_analog;
   logic o_irq;
   logic o_word_pulse;
   int fail_count = 0;
   int total_checks = 0;
   logic [31:0] rd;
   logic [23:0] res;
   int n;
   logic [7:0] ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
   logic [7:0] re [9] = '{8'h81, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] lc [2] = '{8'hDF, 8'h5F};
   int lw [2] = '{48, 36};
   logic [25:0] cr [4] = '{26'h0123456, 26'h0FFFFFF, 26'h2000000, 26'h3FFFFFF};
   logic [23:0] ce [4] = '{24'h123456, 24'h7FFFFF, 24'h800000, 24'hFFFFFF};
   logic [7:0] rc [7] = '{8'hDF, 8'h4F, 8'h5F, 8'h8F, 8'h0F, 8'hDF, 8'hDE};
   logic [7:0] rv [7] = '{8'h1F, 8'h1F, 8'h1F, 8'h1F, 8'h1F, 8'h00, 8'h1F};
   int rp [7] = '{12, 24, 12, 30, 60, 24, 24};
   logic [7:0] mi [6] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00};
   logic [7:0] mc [6] = '{8'h07, 8'h03, 8'h00, 8'h01, 8'h08, 8'h00};
   logic [5:0] mm [6] = '{6'h3C, 6'h3C, 6'h3F, 6'h3B, 6'h01, 6'h20};
   logic [5:0] me [6] = '{6'h20, 6'h34, 6'h3C, 6'h3A, 6'h01, 6'h00};

   always #10 i_clk = ~i_clk;

   delta_sigma_adc_control uut (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_address(i_address),
      .i_read(i_read),
      .i_write(i_write),
      .i_writedata(i_writedata),
      .i_byteenable(i_byteenable),
      .i_raw_data(i_raw_data),
      .o_readdata(o_readdata),
      .o_waitrequest(o_waitrequest),
      .o_analog(o_analog),
      .o_irq(o_irq),
      .o_word_pulse(o_word_pulse)
   );

   // ==========================================================================
   // Tasks
   // ==========================================================================
   task automatic end_of_test();
      if (fail_count == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // A wait that runs out counts as a mismatch and closes the run.
   task automatic hang();
      chk(32'h0, 32'h1);
      end_of_test();
   endtask : hang

   // The request stays up until the edge that samples waitrequest low.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge i_clk);
      i_address <= a;
      i_writedata <= {24'h0, d};
      i_write <= wr;
      i_read <= ~wr;
      do begin
         @(posedge i_clk);
         k++;
      end while (o_waitrequest !== 1'b0 && k < 20);
      if (k >= 20) hang();
      rd = o_readdata;
      i_write <= 1'b0;
      i_read <= 1'b0;
   endtask : bus

   task automatic wait_pulse(output int c);
      c = 0;
      do begin
         @(posedge i_clk);
         c++;
      end while (o_word_pulse !== 1'b1 && c < 3000);
      if (c >= 3000) hang();
   endtask : wait_pulse

   task automatic count_pulses(input int len, output int p);
      p = 0;
      repeat (len) begin
         @(posedge i_clk);
         if (o_word_pulse === 1'b1) p++;
      end
   endtask : count_pulses

   task automatic read_res(output logic [23:0] r);
      bus(1'b0, `OFS_RES_LOW, 8'h00);
      r[7:0] = rd[7:0];
      bus(1'b0, `OFS_RES_MID, 8'h00);
      r[15:8] = rd[7:0];
      bus(1'b0, `OFS_RES_HIGH, 8'h00);
      r[23:16] = rd[7:0];
   endtask : read_res

   // ==========================================================================
   // Main sequence
   // ==========================================================================
   initial begin
      repeat (6) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      chk({26'h0, o_analog}, 32'h0);
      for (int i = 0; i < 9; i++) begin
         bus(1'b0, ra[i], 8'h00);
         chk(rd, {24'h0, re[i]});
      end
      bus(1'b1, `OFS_CLK_SETUP, 8'h1F);
      bus(1'b1, `OFS_INT_CTL, 8'h03);
      i_raw_data <= cr[0];
      // Filter reset held high must not start; the falling write does.
      for (int i = 0; i < 2; i++) begin
         bus(1'b1, `OFS_CTL_ZERO, lc[i]);
         bus(1'b1, `OFS_CTL_ONE, 8'h01);
         count_pulses(60, n);
         chk(n, 0);
         bus(1'b1, `OFS_CTL_ONE, 8'h00);
         wait_pulse(n);
         chk(n >= lw[i] - 3 && n <= lw[i] + 3, 1);
      end
      bus(1'b0, `OFS_CTL_ONE, 8'h00);
      chk(rd, 32'h10);
      bus(1'b0, `OFS_INT_CTL, 8'h00);
      chk(rd, 32'h07);
      chk(o_irq, 1'b1);
      bus(1'b1, `OFS_CTL_ONE, 8'h01);
      bus(1'b0, `OFS_CTL_ONE, 8'h00);
      chk(rd, 32'h01);
      bus(1'b1, `OFS_CTL_ONE, 8'h00);
      for (int i = 0; i < 4; i++) begin
         i_raw_data <= cr[i];
         wait_pulse(n);
         wait_pulse(n);
         read_res(res);
         chk(res, ce[i]);
      end
      // The first word after a rate change may be partial, so the third gap is timed.
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, `OFS_CTL_ZERO, rc[i]);
         bus(1'b1, `OFS_CLK_SETUP, rv[i]);
         wait_pulse(n);
         wait_pulse(n);
         wait_pulse(n);
         chk(n, rp[i]);
      end
      bus(1'b1, `OFS_CTL_ZERO, 8'hDF);
      bus(1'b1, `OFS_CLK_SETUP, 8'h1F);
      // A write without the low byte enable must leave the divider alone.
      i_byteenable <= 4'hE;
      bus(1'b1, `OFS_CLK_SETUP, 8'h00);
      i_byteenable <= 4'hF;
      bus(1'b0, `OFS_CLK_SETUP, 8'h00);
      chk(rd, 32'h1F);
      i_raw_data <= 26'h00000AA;
      wait_pulse(n);
      wait_pulse(n);
      bus(1'b1, `OFS_CTL_ONE, 8'h20);
      i_raw_data <= 26'h0000055;
      count_pulses(60, n);
      chk(n, 0);
      bus(1'b0, `OFS_RES_LOW, 8'h00);
      chk(rd, 32'hAA);
      bus(1'b1, `OFS_CTL_ONE, 8'h00);
      wait_pulse(n);
      bus(1'b0, `OFS_RES_LOW, 8'h00);
      chk(rd, 32'h55);
      bus(1'b1, `OFS_INT_CTL, 8'h01);
      wait_pulse(n);
      repeat (2) @(posedge i_clk);
      chk(o_irq, 1'b0);
      bus(1'b0, `OFS_INT_CTL, 8'h00);
      chk(rd, 32'h05);
      bus(1'b1, `OFS_INT_CTL, 8'h07);
      repeat (3) @(posedge i_clk);
      chk(o_irq, 1'b1);
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, `OFS_REF_CTL, mi[i]);
         bus(1'b1, `OFS_CTL_ONE, mc[i]);
         repeat (3) @(posedge i_clk);
         chk({26'h0, o_analog & mm[i]}, {26'h0, me[i]});
      end
      end_of_test();
   end
endmodule : test_delta_sigma_adc_control
